// ===== dsa_pkg.sv
// shared constants and types for the data-space access and stack check block
package dsa_pkg;

	localparam int          DSA_DW          = 16;
	localparam int          DSA_BUS_AW      = 18;
	localparam int          DSA_MEM_AW      = 15;

	// register indices; byte address on the bus is four times the index
	localparam logic [15:0] IDX_WREG0       = 16'h0000;
	localparam logic [15:0] IDX_WREG1       = 16'h0002;
	localparam logic [15:0] IDX_WREG2       = 16'h0004;
	localparam logic [15:0] IDX_WREG3       = 16'h0006;
	localparam logic [15:0] IDX_WREG4       = 16'h8000;
	localparam logic [15:0] IDX_WREG5       = 16'h000A;
	localparam logic [15:0] IDX_WREG6       = 16'h000C;
	localparam logic [15:0] IDX_WREG7       = 16'h000E;
	localparam logic [15:0] IDX_WREG8       = 16'h0010;
	localparam logic [15:0] IDX_WREG9       = 16'h0012;
	localparam logic [15:0] IDX_WREG10      = 16'h0014;
	localparam logic [15:0] IDX_WREG11      = 16'h0016;
	localparam logic [15:0] IDX_WREG12      = 16'h0018;
	localparam logic [15:0] IDX_WREG13      = 16'h001A;
	localparam logic [15:0] IDX_WREG14      = 16'h001C;
	localparam logic [15:0] IDX_STACK_PTR   = 16'h001E;
	localparam logic [15:0] IDX_STACK_LIMIT = 16'h0020;
	localparam logic [15:0] IDX_STATUS_LOW  = 16'h0042;
	localparam logic [15:0] IDX_TRAP_STAT   = 16'h0100;
	localparam logic [15:0] IDX_TRAP_CLR    = 16'h0102;
	localparam logic [15:0] IDX_TRAP_EN     = 16'h0104;

	// trap status bit positions
	localparam int          TRAP_ADDR_BIT   = 0;
	localparam int          TRAP_STACK_BIT  = 1;

	localparam logic [15:0] WREG_RST        = 16'h0000;
	localparam logic [15:0] STACK_PTR_RST   = 16'h0800;
	localparam logic [15:0] STACK_FLOOR     = 16'h0800;
	localparam logic [15:0] BYTE_STEP       = 16'h0001;
	localparam logic [15:0] WORD_STEP       = 16'h0002;
	localparam logic [3:0]  STACK_PTR_NUM   = 4'hF;
	localparam logic [1:0]  TRAP_RST        = 2'h0;

	typedef enum logic [3:0] {
		OP_NOP      = 4'h0,
		OP_READ     = 4'h1,
		OP_WRITE    = 4'h2,
		OP_YREAD    = 4'h3,
		OP_PUSH     = 4'h4,
		OP_POP      = 4'h5,
		OP_CALLPUSH = 4'h6,
		OP_EXCPUSH  = 4'h7,
		OP_SEXT     = 4'h8,
		OP_ZEXT     = 4'h9
	} dsa_op_e;

	typedef enum logic [1:0] {
		AM_INDIRECT = 2'h0,
		AM_NEAR     = 2'h1,
		AM_FAR      = 2'h2
	} dsa_am_e;

endpackage : dsa_pkg

// ===== dsa_byte_lane.sv
// byte lane steering between a word-organised memory and the byte-addressed core
`timescale 1ns/1ps

module dsa_byte_lane
	import dsa_pkg::*;
(
	input  wire logic [15:0] wdataIn,
	input  wire logic [15:0] rdataIn,
	input  wire logic        eaLsb,
	input  wire logic        isByte,
	input  wire logic        doWrite,
	input  wire logic        blockWrite,
	output logic      [1:0]  laneWe,
	output logic      [15:0] laneWdata,
	output logic      [15:0] rdSel
);

	always_comb
	begin
		laneWe    = 2'h0;
		laneWdata = wdataIn;
		rdSel     = rdataIn;
		if (isByte)
		begin
			// the byte is copied onto both lanes; only the lane that matches the address is strobed
			laneWdata = {wdataIn[7:0], wdataIn[7:0]};
			rdSel     = {8'h00, (eaLsb ? rdataIn[15:8] : rdataIn[7:0])}; // see [RULE2]
			if (doWrite && !blockWrite)
				laneWe = eaLsb ? 2'h2 : 2'h1; // see [RULE4]
		end
		else if (doWrite && !blockWrite)
		begin
			laneWe = 2'h3;
		end
	end

endmodule : dsa_byte_lane

// ===== dsa_core.sv
// data-space access, alignment trap and software stack check logic
// Functional notes
// [RULE1] sixteen-bit registers, byte addressed word memory
// [RULE2] byte read selects lane by address bit
// [RULE3] Y path fetches whole words only
// [RULE4] byte write strobes only matching lane
// [RULE5] post-increment by one byte, two word
// [RULE6] odd word address raises address error
// [RULE7] misaligned read completes, misaligned write suppressed
// [RULE8] byte load keeps destination high byte
// [RULE9] sign-extend and zero-extend working registers
// [RULE10] near region reached by 13-bit field
// [RULE11] move reaches whole space by 16 bits
// [RULE12] register 15 stack grows upward
// [RULE13] call push clears upper pushed byte
// [RULE14] exception push carries status low byte
// [RULE15] limit unreset, bit zero forced low
// [RULE16] push above limit raises stack error
// [RULE17] stack address below floor raises error
// [RULE18] software avoids stack read after limit write
// [RULE19] separate address and stack trap pulses
`timescale 1ns/1ps

module dsa_core
	import dsa_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic [DSA_BUS_AW-1:0] avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic                  opValid,
	output logic                       opReady,
	input  wire dsa_op_e               opCode,
	input  wire logic                  opByte,
	input  wire dsa_am_e               opMode,
	input  wire logic [3:0]            opPtr,
	input  wire logic                  opPostInc,
	input  wire logic [3:0]            opDest,
	input  wire logic [15:0]           opAddr,
	input  wire logic [15:0]           opWdata,
	input  wire logic [23:0]           pcValue,
	input  wire logic [7:0]            statusLowByte,
	output logic                       opDone,
	output logic      [15:0]           xRdData,
	output logic      [15:0]           yRdData,
	output logic      [DSA_MEM_AW-1:0] memAddr,
	output logic                       memRe,
	output logic      [1:0]            memWe,
	output logic      [15:0]           memWdata,
	input  wire logic [15:0]           memRdata,
	output logic                       addrErrTrap,
	output logic                       stackErrTrap,
	output logic                       irq
);

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_MEM    = 3'b010,
		ST_RDWAIT = 3'b100
	} dsa_state_e;

	////////////////////////////////////////////////////////////////////////////////
	// functions

	// bus index to working register number, hit flag in bit 4
	function automatic logic [4:0] wregDecode(input logic [15:0] idx);
		logic [4:0] res;
		res = 5'h00;
		unique case (idx)
			IDX_WREG0:     res = 5'h10;
			IDX_WREG1:     res = 5'h11;
			IDX_WREG2:     res = 5'h12;
			IDX_WREG3:     res = 5'h13;
			IDX_WREG4:     res = 5'h14;
			IDX_WREG5:     res = 5'h15;
			IDX_WREG6:     res = 5'h16;
			IDX_WREG7:     res = 5'h17;
			IDX_WREG8:     res = 5'h18;
			IDX_WREG9:     res = 5'h19;
			IDX_WREG10:    res = 5'h1A;
			IDX_WREG11:    res = 5'h1B;
			IDX_WREG12:    res = 5'h1C;
			IDX_WREG13:    res = 5'h1D;
			IDX_WREG14:    res = 5'h1E;
			IDX_STACK_PTR: res = 5'h1F;
			default:       res = 5'h00;
		endcase
		return res;
	endfunction : wregDecode

	function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] be);
		return {(be[1] ? nw[15:8] : old[15:8]), (be[0] ? nw[7:0] : old[7:0])};
	endfunction : laneMerge

	function automatic logic isPushOp(input dsa_op_e op);
		return (op == OP_PUSH) || (op == OP_CALLPUSH) || (op == OP_EXCPUSH);
	endfunction : isPushOp

	////////////////////////////////////////////////////////////////////////////////
	// state

	dsa_state_e  state_r;
	logic [15:0] wreg_r [16];          // see [RULE1]
	logic [15:0] stackLimit_r;
	logic [1:0]  trapStat_r;
	logic [1:0]  trapEn_r;
	logic        ack_r;
	dsa_op_e     opR_r;
	logic        byteR_r;
	logic [3:0]  destR_r;
	logic [15:0] eaR_r;
	logic        misR_r;
	logic        stkR_r;
	logic        hiPend_r;
	logic [15:0] hiWord_r;

	logic [15:0] stackPtr;
	logic [15:0] ea;
	logic        usesSp;
	logic        wordAcc;
	logic        misalign;
	logic        stackErr;
	logic        isWrite;
	logic        accept;
	logic        finish;
	logic [15:0] hiEa;
	logic        hiStackErr;
	logic [1:0]  laneWe;
	logic [15:0] laneWdata;
	logic [15:0] rdSel;
	logic [15:0] busIdx;
	logic [4:0]  busWreg;
	logic        busWr;
	logic [1:0]  busBe;
	logic [15:0] busWd;
	logic [15:0] step;
	logic [15:0] pushData;
	logic [15:0] limitMerged;

	assign stackPtr = wreg_r[STACK_PTR_NUM];
	assign opReady  = (state_r == ST_IDLE);
	assign accept   = opValid && opReady && (opCode != OP_NOP);
	assign busIdx   = avs_address[DSA_BUS_AW-1:2];
	assign busWreg  = wregDecode(busIdx);
	assign busWr    = avs_write && ack_r;
	assign busBe    = avs_byteenable[1:0];
	assign busWd    = avs_writedata[15:0];
	assign hiEa     = eaR_r + WORD_STEP;
	assign hiStackErr = (hiEa > stackLimit_r) || (hiEa < STACK_FLOOR);
	assign limitMerged = laneMerge(stackLimit_r, busWd, busBe);

	////////////////////////////////////////////////////////////////////////////////
	// effective address and checks

	always_comb
	begin
		ea       = 16'h0000;
		usesSp   = 1'b0;
		pushData = opWdata;
		unique case (opCode)
			OP_READ, OP_WRITE, OP_YREAD:
			begin
				unique case (opMode)
					AM_NEAR:  ea = {3'h0, opAddr[12:0]};       // see [RULE10]
					AM_FAR:   ea = opAddr;                      // see [RULE11]
					default:  ea = wreg_r[opPtr];
				endcase
				usesSp = (opMode == AM_INDIRECT) && (opPtr == STACK_PTR_NUM);
			end
			OP_PUSH:
			begin
				ea     = stackPtr;                              // see [RULE12]
				usesSp = 1'b1;
			end
			OP_CALLPUSH, OP_EXCPUSH:
			begin
				ea       = stackPtr;
				usesSp   = 1'b1;
				pushData = pcValue[15:0];
			end
			OP_POP:
			begin
				ea     = stackPtr - WORD_STEP;                  // see [RULE12]
				usesSp = 1'b1;
			end
			default:
			begin
				ea     = 16'h0000;
				usesSp = 1'b0;
			end
		endcase
	end

	// the Y path has no byte lane, so a Y fetch is always a word
	assign wordAcc  = !opByte || (opCode == OP_YREAD) || isPushOp(opCode) || (opCode == OP_POP); // see [RULE3]
	assign misalign = wordAcc && ea[0];                                              // see [RULE6]
	assign isWrite  = (opCode == OP_WRITE) || isPushOp(opCode);
	// equal to the limit is still legal; only a write past it traps
	assign stackErr = usesSp && ((isWrite && (ea > stackLimit_r)) || (ea < STACK_FLOOR)); // see [RULE16] [RULE17]
	assign step     = (opByte && (opCode != OP_YREAD)) ? BYTE_STEP : WORD_STEP;      // see [RULE5]

	dsa_byte_lane u_lane (
		.wdataIn    (pushData),
		.rdataIn    (memRdata),
		.eaLsb      (ea[0]),
		.isByte     (!wordAcc),
		.doWrite    (isWrite),
		.blockWrite (misalign),
		.laneWe     (laneWe),
		.laneWdata  (laneWdata),
		.rdSel      ()
	);

	// read-side steering uses the address held for the access in flight
	assign rdSel = byteR_r ? {8'h00, (eaR_r[0] ? memRdata[15:8] : memRdata[7:0])} : memRdata; // see [RULE2]

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	assign finish = ((state_r == ST_MEM) && !hiPend_r && (opR_r != OP_READ) && (opR_r != OP_POP)
		&& (opR_r != OP_YREAD)) || (state_r == ST_RDWAIT);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			state_r <= ST_IDLE;
		else
		begin
			unique case (state_r)
				ST_IDLE:
					if (accept && (opCode != OP_SEXT) && (opCode != OP_ZEXT))
						state_r <= ST_MEM;
				ST_MEM:
					if (!hiPend_r)
						state_r <= ((opR_r == OP_READ) || (opR_r == OP_POP) || (opR_r == OP_YREAD))
							? ST_RDWAIT : ST_IDLE;
				ST_RDWAIT:
					state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			opR_r    <= OP_NOP;
			byteR_r  <= 1'b0;
			destR_r  <= 4'h0;
			eaR_r    <= 16'h0000;
			misR_r   <= 1'b0;
			stkR_r   <= 1'b0;
			hiPend_r <= 1'b0;
			hiWord_r <= 16'h0000;
		end
		else if (accept)
		begin
			opR_r    <= opCode;
			byteR_r  <= !wordAcc;
			destR_r  <= opDest;
			eaR_r    <= ea;
			misR_r   <= misalign;
			stkR_r   <= stackErr;
			hiPend_r <= (opCode == OP_CALLPUSH) || (opCode == OP_EXCPUSH);
			if (opCode == OP_EXCPUSH)
				hiWord_r <= {statusLowByte, pcValue[23:16]}; // see [RULE14]
			else
				hiWord_r <= {8'h00, pcValue[23:16]};        // see [RULE13]
		end
		else if ((state_r == ST_MEM) && hiPend_r)
		begin
			hiPend_r <= 1'b0;
			eaR_r    <= hiEa;
			misR_r   <= misR_r | hiEa[0];
			stkR_r   <= stkR_r | hiStackErr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// memory port

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			memAddr  <= '0;
			memRe    <= 1'b0;
			memWe    <= 2'h0;
			memWdata <= 16'h0000;
		end
		else
		begin
			memRe <= 1'b0;
			memWe <= 2'h0;
			if (accept && (opCode != OP_SEXT) && (opCode != OP_ZEXT))
			begin
				memAddr  <= ea[15:1];
				memRe    <= !isWrite;
				memWe    <= laneWe;               // see [RULE4] [RULE7]
				memWdata <= laneWdata;
			end
			else if ((state_r == ST_MEM) && hiPend_r)
			begin
				memAddr  <= hiEa[15:1];
				memWe    <= hiEa[0] ? 2'h0 : 2'h3; // see [RULE7]
				memWdata <= hiWord_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// completion, read data and trap pulses

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			opDone       <= 1'b0;
			xRdData      <= 16'h0000;
			yRdData      <= 16'h0000;
			addrErrTrap  <= 1'b0;
			stackErrTrap <= 1'b0;
		end
		else
		begin
			opDone       <= finish || (accept && ((opCode == OP_SEXT) || (opCode == OP_ZEXT)));
			// traps pulse in the completion cycle, together with opDone, so the faulting state can be examined
			addrErrTrap  <= finish && misR_r;     // see [RULE7] [RULE19]
			stackErrTrap <= finish && stkR_r;     // see [RULE19]
			if (state_r == ST_RDWAIT)
			begin
				if (opR_r == OP_YREAD)
					yRdData <= memRdata;          // see [RULE3]
				else
					xRdData <= rdSel;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// working registers

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < 16; i++)
				wreg_r[i] <= WREG_RST;
			wreg_r[STACK_PTR_NUM] <= STACK_PTR_RST;
		end
		else
		begin
			if (busWr && busWreg[4])
				wreg_r[busWreg[3:0]] <= laneMerge(wreg_r[busWreg[3:0]], busWd, busBe);
			if (accept)
			begin
				unique case (opCode)
					OP_SEXT:
						wreg_r[opDest] <= {{8{wreg_r[opDest][7]}}, wreg_r[opDest][7:0]}; // see [RULE9]
					OP_ZEXT:
						wreg_r[opDest] <= {8'h00, wreg_r[opDest][7:0]};                  // see [RULE9]
					OP_PUSH, OP_CALLPUSH, OP_EXCPUSH:
						wreg_r[STACK_PTR_NUM] <= stackPtr + WORD_STEP;                    // see [RULE12]
					OP_POP:
						wreg_r[STACK_PTR_NUM] <= ea;
					default:
						if ((opMode == AM_INDIRECT) && opPostInc)
							wreg_r[opPtr] <= wreg_r[opPtr] + step;                        // see [RULE5]
				endcase
			end
			if ((state_r == ST_MEM) && hiPend_r)
				wreg_r[STACK_PTR_NUM] <= stackPtr + WORD_STEP;
			// a misaligned read still completes into the destination
			if ((state_r == ST_RDWAIT) && (opR_r != OP_YREAD))
			begin
				if (byteR_r)
					wreg_r[destR_r] <= {wreg_r[destR_r][15:8], rdSel[7:0]};           // see [RULE8] [RULE7]
				else
					wreg_r[destR_r] <= memRdata;
			end
		end
	end

	// no reset on the limit; software must load it before relying on the check
	always_ff @(posedge ref_clk)
	begin
		if (busWr && (busIdx == IDX_STACK_LIMIT))
			stackLimit_r <= {limitMerged[15:1], 1'b0}; // see [RULE15]
	end

	////////////////////////////////////////////////////////////////////////////////
	// trap status and interrupt

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			trapStat_r <= TRAP_RST;
			trapEn_r   <= TRAP_RST;
		end
		else
		begin
			if (busWr && (busIdx == IDX_TRAP_EN))
				trapEn_r <= busWd[1:0];
			// a new trap in the clearing cycle survives
			trapStat_r <= ((busWr && (busIdx == IDX_TRAP_CLR)) ? (trapStat_r & ~busWd[1:0]) : trapStat_r)
				| {stackErrTrap, addrErrTrap};
		end
	end

	assign irq = |(trapStat_r & trapEn_r);

	////////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle on every access

	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ack_r        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			ack_r <= (avs_read || avs_write) && !ack_r;
			if (avs_read && !ack_r)
			begin
				if (busWreg[4])
					avs_readdata <= {16'h0000, wreg_r[busWreg[3:0]]};
				else if (busIdx == IDX_STACK_LIMIT)
					avs_readdata <= {16'h0000, stackLimit_r};
				else if (busIdx == IDX_STATUS_LOW)
					avs_readdata <= {24'h00_0000, statusLowByte};
				else if (busIdx == IDX_TRAP_STAT)
					avs_readdata <= {30'h0000_0000, trapStat_r};
				else if (busIdx == IDX_TRAP_EN)
					avs_readdata <= {30'h0000_0000, trapEn_r};
				else
					avs_readdata <= 32'h0000_0000;
			end
		end
	end

endmodule : dsa_core

// ===== dsa_mem_model.sv
// word-wide data memory model standing behind the access block
`timescale 1ns/1ps

module dsa_mem_model
	import dsa_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic [DSA_MEM_AW-1:0] memAddr,
	input  wire logic                  memRe,
	input  wire logic [1:0]            memWe,
	input  wire logic [15:0]           memWdata,
	output logic      [15:0]           memRdata
);
	logic [15:0] store [0:(1 << DSA_MEM_AW)-1];

	initial
	begin
		for (int i = 0; i < (1 << DSA_MEM_AW); i++)
			store[i] = 16'h0000;
	end

	////////////////////////////////
	always @(posedge ref_clk)
	begin
		if (memWe[0])
			store[memAddr][7:0] <= memWdata[7:0];
		if (memWe[1])
			store[memAddr][15:8] <= memWdata[15:8];
		// data stands one cycle only; scrambled so a late sample shows
		if (memRe)
			memRdata <= store[memAddr];
		else
			memRdata <= ~memRdata;
	end
endmodule : dsa_mem_model

// ===== dsa_core_checker.sv
// concurrent checks on the ports of the data-space access block
`timescale 1ns/1ps

module dsa_core_checker
	import dsa_pkg::*;
(
	input wire logic                  ref_clk,
	input wire logic                  rst,
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic                  avs_waitrequest,
	input wire logic                  opValid,
	input wire logic                  opReady,
	input wire dsa_op_e               opCode,
	input wire logic                  opByte,
	input wire dsa_am_e               opMode,
	input wire logic [15:0]           opAddr,
	input wire logic                  opDone,
	input wire logic [15:0]           xRdData,
	input wire logic [DSA_MEM_AW-1:0] memAddr,
	input wire logic                  memRe,
	input wire logic [1:0]            memWe,
	input wire logic                  addrErrTrap,
	input wire logic                  stackErrTrap
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	logic acc;
	logic direct;
	assign acc = opValid && opReady && opCode != OP_NOP;
	assign direct = opMode != AM_INDIRECT;

	////////////////////////////////
	a_read_timing: assert property (acc && opCode == OP_READ |=> !opReady [*2] ##1 opDone && opReady)
		else $error("read op timing wrong");
	a_direct_addr: assert property (acc && opCode == OP_READ && direct |=> memRe && memAddr ==
		($past(opMode) == AM_NEAR ? {3'h0, $past(opAddr[12:1])} : $past(opAddr[15:1])))
		else $error("direct word address wrong");
	a_byte_lane: assert property (acc && opCode == OP_WRITE && opByte && direct |=>
		memWe == ($past(opAddr[0]) ? 2'h2 : 2'h1))
		else $error("byte write lane wrong");
	a_odd_write: assert property (acc && opCode == OP_WRITE && !opByte && direct && opAddr[0] |=>
		memWe == 2'h0 ##1 (memWe == 2'h0 && addrErrTrap && opDone))
		else $error("misaligned write not suppressed");
	a_read_trap: assert property (acc && opCode == OP_READ && !opByte && direct |-> ##3
		opDone && addrErrTrap == $past(opAddr[0], 3))
		else $error("word read alignment trap wrong");
	a_byte_high: assert property (acc && opCode == OP_READ && opByte |-> ##3 xRdData[15:8] == 8'h00)
		else $error("byte read high half not clear");
	a_yread_word: assert property (acc && opCode == OP_YREAD |=> memRe ##2 opDone)
		else $error("y read timing wrong");
	a_ext_timing: assert property (acc && (opCode == OP_SEXT || opCode == OP_ZEXT) |=> opDone && !memRe)
		else $error("extend op timing wrong");
	a_push_timing: assert property (acc && opCode == OP_PUSH |=> !opReady ##1 opDone)
		else $error("push timing wrong");
	a_addr_trap: assert property (addrErrTrap |-> opDone)
		else $error("address trap outside op end");
	a_stack_trap: assert property (stackErrTrap |-> opDone)
		else $error("stack trap outside op end");
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus wait longer than one cycle");

	c_exc_push: cover property (acc && opCode == OP_EXCPUSH);
	c_stack_err: cover property (stackErrTrap);
	c_addr_err: cover property (addrErrTrap && memWe == 2'h0);
endmodule : dsa_core_checker

// ===== test_data_space_access_stack_check.sv
// self-checking bench for the data-space access and stack check block
`timescale 1ns/1ps

module test_data_space_access_stack_check
	import dsa_pkg::*;
;
	logic        ref_clk = 1'h0, rst = 1'h1, avsRd = 1'h0, avsWr = 1'h0;
	logic [17:0] avsAddr = 18'h0;
	logic [31:0] avsWd = 32'h0, avsRdData;
	logic [3:0]  avsBe = 4'h3, opPtr = 4'h0, opDest = 4'h0;
	logic        opValid = 1'h0, opByte = 1'h0, opPostInc = 1'h0;
	dsa_op_e     opCode = OP_NOP;
	dsa_am_e     opMode = AM_FAR;
	logic [15:0] opAddr = 16'h0, opWdata = 16'h0, xRd, yRd, memRdata, memWdata, rv;
	logic [23:0] pcValue = 24'h123456;
	logic [7:0]  statusLowByte = 8'h00;
	logic [14:0] memAddr;
	logic [1:0]  memWe, tr;
	logic        waitReq, opReady, opDone, memRe, ae, se, irq;
	int          errCount = 0, numChecks = 0;

	dsa_core dut_u (.ref_clk, .rst, .avs_address(avsAddr), .avs_read(avsRd), .avs_write(avsWr),
		.avs_writedata(avsWd), .avs_byteenable(avsBe), .avs_readdata(avsRdData),
		.avs_waitrequest(waitReq), .opValid, .opReady, .opCode, .opByte, .opMode, .opPtr,
		.opPostInc, .opDest, .opAddr, .opWdata, .pcValue, .statusLowByte, .opDone,
		.xRdData(xRd), .yRdData(yRd), .memAddr, .memRe, .memWe, .memWdata, .memRdata,
		.addrErrTrap(ae), .stackErrTrap(se), .irq);
	dsa_mem_model mem_u (.ref_clk, .memAddr, .memRe, .memWe, .memWdata, .memRdata);

	initial
		forever #12.5 ref_clk = ~ref_clk;

	////////////////////////////////
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		numChecks++;
		if (g !== e)
		begin
			errCount++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task chkf(input string n, input logic e, input logic g);
		numChecks++;
		if (g !== e)
		begin
			errCount++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask : chkf

	// request held until waitrequest is sampled low at a rising edge; the watchdog ends a hang
	task bus(input logic w, input logic [15:0] i, input logic [15:0] d, input logic [3:0] be);
		@(posedge ref_clk);
		avsAddr <= {i, 2'h0};
		avsRd <= !w;
		avsWr <= w;
		avsWd <= {16'h0, d};
		avsBe <= be;
		do
			@(posedge ref_clk);
		while (waitReq !== 1'b0);
		rv = avsRdData[15:0];
		avsRd <= 1'h0;
		avsWr <= 1'h0;
	endtask : bus

	task rdchk(input string n, input logic [15:0] i, input logic [15:0] e);
		bus(1'h0, i, 16'h0, 4'h3);
		chk(n, e, rv);
	endtask : rdchk

	task op(input dsa_op_e c, input dsa_am_e m, input logic b, input logic [15:0] a,
		input logic [15:0] w = 16'h0, input logic [3:0] p = 4'h0, input logic pi = 1'h0,
		input logic [3:0] d = 4'h0);
		@(posedge ref_clk);
		opCode <= c;
		opMode <= m;
		opByte <= b;
		opAddr <= a;
		opWdata <= w;
		opPtr <= p;
		opPostInc <= pi;
		opDest <= d;
		opValid <= 1'h1;
		do
			@(posedge ref_clk);
		while (opReady !== 1'b1);
		opValid <= 1'h0;
		opCode <= OP_NOP;
		do
			@(negedge ref_clk);
		while (opDone !== 1'b1);
		tr = {ae, se};
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask : op

	task endOfTest;
		$display("checks %0d mismatches %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : endOfTest

	////////////////////////////////
	task tRegs;
		rdchk("wreg4", IDX_WREG4, WREG_RST);
		rdchk("sp", IDX_STACK_PTR, STACK_PTR_RST);
		bus(1'h1, IDX_WREG4, 16'hA5C3, 4'h3);
		bus(1'h1, IDX_WREG4, 16'h0000, 4'h1);
		rdchk("wreg4 lane", IDX_WREG4, 16'hA500);
		bus(1'h1, IDX_STACK_LIMIT, 16'h1001, 4'h3);
		rdchk("limit", IDX_STACK_LIMIT, 16'h1000);
		rdchk("unmapped", 16'h0200, 16'h0000);
		$display("test regs done");
	endtask : tRegs

	task tBytes;
		op(OP_WRITE, AM_FAR, 1'h0, 16'h2000, 16'h1234);
		op(OP_WRITE, AM_FAR, 1'h1, 16'h2001, 16'h00AB);
		chk("lane", 16'hAB34, mem_u.store[15'h1000]);
		bus(1'h1, IDX_WREG1, 16'h5566, 4'h3);
		op(OP_READ, AM_FAR, 1'h1, 16'h2001, 16'h0, 4'h0, 1'h0, 4'h1);
		chk("xbyte", 16'h00AB, xRd);
		rdchk("byte load", IDX_WREG1, 16'h55AB);
		op(OP_SEXT, AM_FAR, 1'h0, 16'h0, 16'h0, 4'h0, 1'h0, 4'h1);
		rdchk("sext", IDX_WREG1, 16'hFFAB);
		op(OP_ZEXT, AM_FAR, 1'h0, 16'h0, 16'h0, 4'h0, 1'h0, 4'h1);
		rdchk("zext", IDX_WREG1, 16'h00AB);
		op(OP_YREAD, AM_FAR, 1'h1, 16'h2000);
		chk("yword", 16'hAB34, yRd);
		op(OP_WRITE, AM_FAR, 1'h0, 16'h1000, 16'h4321);
		op(OP_READ, AM_NEAR, 1'h0, 16'hF000, 16'h0, 4'h0, 1'h0, 4'h2);
		chk("near", 16'h4321, xRd);
		chkf("even word", 1'h0, tr[1]);
		$display("test bytes done");
	endtask : tBytes

	task tPostInc;
		bus(1'h1, IDX_WREG2, 16'h2000, 4'h3);
		op(OP_READ, AM_INDIRECT, 1'h1, 16'h0, 16'h0, 4'h2, 1'h1, 4'h3);
		chk("lsb lane", 16'h0034, xRd);
		rdchk("ptr byte", IDX_WREG2, 16'h2001);
		op(OP_READ, AM_INDIRECT, 1'h1, 16'h0, 16'h0, 4'h2, 1'h1, 4'h3);
		op(OP_READ, AM_INDIRECT, 1'h0, 16'h0, 16'h0, 4'h2, 1'h1, 4'h3);
		rdchk("ptr word", IDX_WREG2, 16'h2004);
		$display("test post increment done");
	endtask : tPostInc

	task tAlign;
		op(OP_WRITE, AM_FAR, 1'h0, 16'h2001, 16'h7777);
		chkf("odd write", 1'h1, tr[1]);
		chk("no write", 16'hAB34, mem_u.store[15'h1000]);
		bus(1'h1, IDX_WREG3, 16'hFFFF, 4'h3);
		op(OP_READ, AM_NEAR, 1'h0, 16'h1001, 16'h0, 4'h0, 1'h0, 4'h3);
		chkf("odd read", 1'h1, tr[1]);
		rdchk("read completes", IDX_WREG3, 16'h4321);
		rdchk("status", IDX_TRAP_STAT, 16'h0001);
		chkf("masked", 1'h0, irq);
		bus(1'h1, IDX_TRAP_EN, 16'h0003, 4'h3);
		@(negedge ref_clk);
		chkf("irq", 1'h1, irq);
		bus(1'h1, IDX_TRAP_CLR, 16'h0001, 4'h3);
		rdchk("cleared", IDX_TRAP_STAT, 16'h0000);
		chkf("irq low", 1'h0, irq);
		$display("test alignment done");
	endtask : tAlign

	task tStack;
		bus(1'h1, IDX_STACK_LIMIT, 16'h0802, 4'h3);
		op(OP_PUSH, AM_INDIRECT, 1'h0, 16'h0, 16'h1111);
		op(OP_PUSH, AM_INDIRECT, 1'h0, 16'h0, 16'h2222);
		chkf("push at limit", 1'h0, tr[0]);
		op(OP_PUSH, AM_INDIRECT, 1'h0, 16'h0, 16'h3333);
		chkf("push past limit", 1'h1, tr[0]);
		chk("stack w0", 16'h1111, mem_u.store[15'h0400]);
		chk("stack w1", 16'h2222, mem_u.store[15'h0401]);
		bus(1'h1, IDX_STACK_PTR, 16'h0802, 4'h3);
		op(OP_POP, AM_INDIRECT, 1'h0, 16'h0, 16'h0, 4'h0, 1'h0, 4'h5);
		rdchk("pop", IDX_WREG5, 16'h1111);
		rdchk("sp pop", IDX_STACK_PTR, 16'h0800);
		op(OP_POP, AM_INDIRECT, 1'h0, 16'h0, 16'h0, 4'h0, 1'h0, 4'h5);
		chkf("underflow", 1'h1, tr[0]);
		bus(1'h1, IDX_STACK_LIMIT, 16'h0FFE, 4'h3);
		bus(1'h1, IDX_STACK_PTR, 16'h0900, 4'h3);
		op(OP_CALLPUSH, AM_INDIRECT, 1'h0, 16'h0);
		chk("call lo", 16'h3456, mem_u.store[15'h0480]);
		chk("call hi", 16'h0012, mem_u.store[15'h0481]);
		@(posedge ref_clk);
		pcValue <= 24'hABCDEF;
		statusLowByte <= 8'h5A;
		op(OP_EXCPUSH, AM_INDIRECT, 1'h0, 16'h0);
		chk("exc hi", 16'h5AAB, mem_u.store[15'h0483]);
		rdchk("sp exc", IDX_STACK_PTR, 16'h0908);
		$display("test stack done");
	endtask : tStack

	////////////////////////////////
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'h0;
		tRegs;
		tBytes;
		tPostInc;
		tAlign;
		tStack;
		endOfTest;
	end

	initial
	begin
		repeat (5000) @(posedge ref_clk);
		errCount++;
		endOfTest;
	end
endmodule : test_data_space_access_stack_check

bind dsa_core dsa_core_checker chk_u (.ref_clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
	.opValid, .opReady, .opCode, .opByte, .opMode, .opAddr, .opDone, .xRdData, .memAddr,
	.memRe, .memWe, .addrErrTrap, .stackErrTrap);
